// ### logic/pmw_defs.svh
// Register offsets, field positions, reset values and limits of the block
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PMW_OFF_CTRL     8'h00
`define PMW_OFF_WIN      8'h04
`define PMW_OFF_MISS_LIM 8'h08
`define PMW_OFF_TOL      8'h0c
`define PMW_OFF_GAP      8'h10
`define PMW_OFF_PHASE    8'h14
`define PMW_OFF_PRESET   8'h18
`define PMW_OFF_TAUGHT   8'h1c
`define PMW_OFF_STAT     8'h20
`define PMW_OFF_INT_STAT 8'h24
`define PMW_OFF_INT_CLR  8'h28
`define PMW_OFF_INT_EN   8'h2c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMW_CTRL_MODE_LSB 0
`define PMW_CTRL_MODE_MSB 1
`define PMW_CTRL_UPD_LSB  4
`define PMW_CTRL_UPD_MSB  6
`define PMW_INT_MARK_OK   0
`define PMW_INT_MARK_REJ  1
`define PMW_INT_ABSENT    2
`define PMW_INT_LEN_UPD   3
`define PMW_INT_GAP_DONE  4
`define PMW_INT_W         5

// ----------------------------------------------------------------------
// Reset values and setting limits
// ----------------------------------------------------------------------
`define PMW_RST_MODE      2'h1
`define PMW_RST_UPD       3'h0
`define PMW_RST_PRESET    24'h0003e8
`define PMW_RST_PHASE     16'h0064
`define PMW_WIN_MAX       14'h270f
`define PMW_MISS_MAX      7'h63
`define PMW_TOL_MAX       10'h3e7
`define PMW_GAP_MAX       14'h270f
`define PMW_UPD_MAX       3'h5

`endif

// ### logic/pmw_pkg.sv
// Types shared by the print-mark window and correction block
`default_nettype none
package pmw_pkg;

  // Cutting mode, as written to the control register
  typedef enum logic [1:0] {
    PMW_MODE_OFF  = 2'b00,
    PMW_MODE_CUT  = 2'b01,
    PMW_MODE_MARK = 2'b10,
    PMW_MODE_RSV  = 2'b11
  } pmw_mode_e;

  // Gap generator sequence
  typedef enum logic [1:0] {
    PMW_GAP_IDLE = 2'b00,
    PMW_GAP_DIV  = 2'b01,
    PMW_GAP_RAMP = 2'b10
  } pmw_gap_e;

  typedef logic [23:0] pmw_len_t;

endpackage : pmw_pkg
`default_nettype wire

// ### logic/pmw_len_avg.sv
// Running sum of measured mark spacings and its mean over a run
`timescale 1ns/1ps
`default_nettype none
module pmw_len_avg (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  // Samples
  input  wire logic              i_add,
  input  wire logic              i_first,
  input  wire pmw_pkg::pmw_len_t i_val,
  input  wire logic [2:0]        i_shift,
  // Mean including the current sample
  output logic [23:0]            o_avg
);
  import pmw_pkg::*;

  logic [27:0] sum_r;
  logic [27:0] sum_nxt;

  // Sum restarts with the first sample of a run
  always_comb begin
    sum_nxt = (i_first ? 28'h0 : sum_r) + {4'h0, i_val};
    o_avg   = 24'(sum_nxt >> i_shift);
  end

  // Sum register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sum_r <= 28'h0;
    end else if (i_add) begin
      sum_r <= sum_nxt;
    end
  end

endmodule : pmw_len_avg
`default_nettype wire

// ### logic/pmw_gap_gen.sv
// Gap profile: ramps an extra travel to the gap distance over the phase
`timescale 1ns/1ps
`default_nettype none
module pmw_gap_gen (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // Start of the post-cut phase and settings
  input  wire logic        i_start,
  input  wire logic [13:0] i_gap,
  input  wire logic [15:0] i_phase,
  // Profile
  output logic [13:0]      o_offs,
  output logic             o_busy,
  output logic             o_done
);
  import pmw_pkg::*;

  pmw_gap_e    state_r;
  logic [13:0] gap_r;
  logic [15:0] ph_r;
  logic [3:0]  idx_r;
  logic [15:0] rem_r;
  logic [13:0] quo_r;
  logic [15:0] cnt_r;
  logic [15:0] err_r;
  logic [16:0] trial;
  logic [16:0] err_sum;
  logic        carry;

  // Restoring division step and ramp remainder
  always_comb begin
    trial   = {rem_r, gap_r[idx_r]};
    err_sum = {1'b0, err_r} + {1'b0, rem_r};
    carry   = err_sum >= {1'b0, ph_r};
  end

  assign o_busy = (state_r != PMW_GAP_IDLE);

  // Divide gap by phase, then add quotient plus spread remainder per cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= PMW_GAP_IDLE;
      gap_r   <= 14'h0;
      ph_r    <= 16'h0;
      idx_r   <= 4'h0;
      rem_r   <= 16'h0;
      quo_r   <= 14'h0;
      cnt_r   <= 16'h0;
      err_r   <= 16'h0;
      o_offs  <= 14'h0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && i_gap != 14'h0) begin
        gap_r  <= i_gap;
        ph_r   <= i_phase;
        idx_r  <= 4'hd;
        rem_r  <= 16'h0;
        quo_r  <= 14'h0;
        o_offs <= 14'h0;
        if (i_phase == 16'h0) begin
          o_offs  <= i_gap;
          o_done  <= 1'b1;
          state_r <= PMW_GAP_IDLE;
        end else begin
          state_r <= PMW_GAP_DIV;
        end
      end else begin
        unique case (state_r)
          PMW_GAP_IDLE: begin
          end
          PMW_GAP_DIV: begin
            if (trial >= {1'b0, ph_r}) begin
              rem_r        <= 16'(trial - {1'b0, ph_r});
              quo_r[idx_r] <= 1'b1;
            end else begin
              rem_r <= trial[15:0];
            end
            idx_r <= idx_r - 4'h1;
            if (idx_r == 4'h0) begin
              state_r <= PMW_GAP_RAMP;
              cnt_r   <= ph_r;
              err_r   <= 16'h0;
            end
          end
          PMW_GAP_RAMP: begin
            // Steeper for short phases, flatter for long ones
            o_offs <= o_offs + quo_r + {13'h0, carry};
            err_r  <= carry ? 16'(err_sum - {1'b0, ph_r}) : err_sum[15:0];
            cnt_r  <= cnt_r - 16'h1;
            if (cnt_r == 16'h1) begin
              state_r <= PMW_GAP_IDLE;
              o_done  <= 1'b1;
            end
          end
          default: begin
            state_r <= PMW_GAP_IDLE;
          end
        endcase
      end
    end
  end

endmodule : pmw_gap_gen
`default_nettype wire

// ### logic/pmw_top.sv
// Print-mark window, missing-mark watch, length correction and gap
//
// How it works
// - Window width 0..9999; zero accepts every detected mark.
// - With a window, marks outside it around the taught spot are ignored.
// - Teach high: next mark rising edge stores its sheet position.
// - Count sheets without a window mark; flag absent at the limit.
// - Missing-mark limit zero disables the absent output.
// - Update setting 0 off, 1 one cycle, 2 two, 3 four cycles.
// - Tolerance 0..999 decides whether a cycle is out of tolerance.
// - Gap 0..9999; nonzero adds extra roll travel after the cut.
// - Gap ramps over post-cut phase after a 14-cycle divide, slope scaled to its length.
// - Mark settings act only in mark mode, not cut-to-length.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_top (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  // Register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  // Photocell and teach pins
  input  wire logic              i_mark,
  input  wire logic              i_teach,
  // Material position and cut strobe from the controller
  input  wire logic [31:0]       i_pos,
  input  wire logic              i_cut_stb,
  // Registration results
  output logic                   o_mark_stb,
  output logic [31:0]            o_mark_pos,
  output logic                   o_mark_absent,
  output pmw_pkg::pmw_len_t      o_len_preset,
  // Gap profile to the roll profile generator
  output logic [13:0]            o_gap_offs,
  output logic                   o_gap_busy,
  // Interrupt
  output logic                   o_irq
);
  import pmw_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [1:0]            mode_r;
  logic [2:0]            upd_r;
  logic [13:0]           win_r;
  logic [6:0]            miss_lim_r;
  logic [9:0]            tol_r;
  logic [13:0]           gap_r;
  logic [15:0]           phase_r;
  pmw_len_t              preset_r;
  logic [`PMW_INT_W-1:0] int_stat_r;
  logic [`PMW_INT_W-1:0] int_en_r;
  logic [`PMW_INT_W-1:0] int_evt;
  logic [2:0]            mark_sync_r;
  logic [1:0]            teach_sync_r;
  logic [31:0]           sheet_base_r;
  logic [31:0]           taught_r;
  logic                  taught_vld_r;
  logic [31:0]           last_mark_r;
  logic                  have_prev_r;
  logic                  got_mark_r;
  logic [6:0]            miss_cnt_r;
  logic [4:0]            run_r;
  logic                  dir_r;
  logic                  absent_d_r;
  logic                  pm_mode;
  logic                  mark_rise;
  logic                  teach_hit;
  logic [31:0]           rel;
  logic [31:0]           wdiff;
  logic [31:0]           wabs;
  logic                  in_win;
  logic                  mark_ok;
  logic                  mark_rej;
  pmw_len_t              meas;
  logic [24:0]           err;
  logic [24:0]           eabs;
  logic                  out_tol;
  logic                  eval;
  logic [4:0]            run_nxt;
  logic [4:0]            req;
  logic                  len_hit;
  logic [23:0]           avg;
  logic                  gap_done;
  logic                  wr_ctrl;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Two stages before use, third stage only for the edge compare
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mark_sync_r  <= 3'h0;
      teach_sync_r <= 2'h0;
    end else begin
      mark_sync_r  <= {mark_sync_r[1:0], i_mark};
      teach_sync_r <= {teach_sync_r[0], i_teach};
    end
  end

  // --------------------------------------------------------------------
  // Mark qualification
  // --------------------------------------------------------------------
  // Window test, teach capture and length error of the current mark
  always_comb begin
    pm_mode   = (mode_r == PMW_MODE_MARK);
    mark_rise = mark_sync_r[1] & ~mark_sync_r[2];
    teach_hit = pm_mode & teach_sync_r[1] & mark_rise;
    rel       = i_pos - sheet_base_r;
    wdiff     = rel - taught_r;
    wabs      = wdiff[31] ? 32'(-wdiff) : wdiff;
    in_win    = (win_r == 14'h0) | ~taught_vld_r | teach_hit
              | (wabs <= {19'h0, win_r[13:1]});
    mark_ok   = pm_mode & mark_rise & in_win;
    mark_rej  = pm_mode & mark_rise & ~in_win;
    meas      = 24'(i_pos - last_mark_r);
    err       = {1'b0, meas} - {1'b0, preset_r};
    eabs      = err[24] ? 25'(-err) : err;
    out_tol   = eabs > {15'h0, tol_r};
    eval      = mark_ok & have_prev_r & (upd_r != 3'h0);
    req       = 5'h1 << (upd_r - 3'h1);
    if (!out_tol) begin
      run_nxt = 5'h0;
    end else if (run_r != 5'h0 && err[24] == dir_r) begin
      run_nxt = run_r + 5'h1;
    end else begin
      run_nxt = 5'h1;
    end
    len_hit   = eval & out_tol & (run_nxt == req);
  end

  // Mean of the measured spacings over the current run
  pmw_len_avg u_avg (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_add     (eval & out_tol),
    .i_first   (run_nxt == 5'h1),
    .i_val     (meas),
    .i_shift   (upd_r - 3'h1),
    .o_avg     (avg)
  );

  // --------------------------------------------------------------------
  // Teach and mark tracking
  // --------------------------------------------------------------------
  // Taught spot is kept relative to the sheet start
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      taught_r     <= 32'h0;
      taught_vld_r <= 1'b0;
    end else if (teach_hit) begin
      taught_r     <= rel;
      taught_vld_r <= 1'b1;
    end
  end

  // Accepted mark strobe and position
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mark_stb  <= 1'b0;
      o_mark_pos  <= 32'h0;
      last_mark_r <= 32'h0;
      have_prev_r <= 1'b0;
    end else begin
      o_mark_stb <= mark_ok;
      if (mark_ok) begin
        o_mark_pos  <= i_pos;
        last_mark_r <= i_pos;
        have_prev_r <= 1'b1;
      end
      if (!pm_mode) begin
        have_prev_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Missing-mark supervision
  // --------------------------------------------------------------------
  // Each cut closes a sheet; a sheet without a window mark counts
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sheet_base_r  <= 32'h0;
      got_mark_r    <= 1'b0;
      miss_cnt_r    <= 7'h0;
      o_mark_absent <= 1'b0;
      absent_d_r    <= 1'b0;
    end else begin
      absent_d_r <= o_mark_absent;
      if (i_cut_stb) begin
        sheet_base_r <= i_pos;
        got_mark_r   <= 1'b0;
        if (!pm_mode || got_mark_r || mark_ok) begin
          miss_cnt_r <= 7'h0;
        end else if (miss_cnt_r != `PMW_MISS_MAX) begin
          miss_cnt_r <= miss_cnt_r + 7'h1;
        end
      end else if (mark_ok) begin
        got_mark_r <= 1'b1;
      end
      o_mark_absent <= pm_mode && (miss_lim_r != 7'h0)
                    && (miss_cnt_r >= miss_lim_r);
    end
  end

  // --------------------------------------------------------------------
  // Length correction run
  // --------------------------------------------------------------------
  // Run of same-direction errors; preset overwritten at the count
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_r    <= 5'h0;
      dir_r    <= 1'b0;
      preset_r <= `PMW_RST_PRESET;
    end else begin
      if (eval) begin
        run_r <= len_hit ? 5'h0 : run_nxt;
        dir_r <= err[24];
      end else if (!pm_mode || upd_r == 3'h0) begin
        run_r <= 5'h0;
      end
      if (i_wr && i_addr == `PMW_OFF_PRESET) begin
        preset_r <= i_wdata[23:0];
      end else if (len_hit) begin
        preset_r <= avg;
      end
    end
  end

  assign o_len_preset = preset_r;

  // --------------------------------------------------------------------
  // Gap after the cut
  // --------------------------------------------------------------------
  pmw_gap_gen u_gap (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_start   (i_cut_stb),
    .i_gap     (gap_r),
    .i_phase   (phase_r),
    .o_offs    (o_gap_offs),
    .o_busy    (o_gap_busy),
    .o_done    (gap_done)
  );

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  assign wr_ctrl = i_wr && (i_addr == `PMW_OFF_CTRL);

  // Settings are clamped to their ranges on write
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r     <= `PMW_RST_MODE;
      upd_r      <= `PMW_RST_UPD;
      win_r      <= 14'h0;
      miss_lim_r <= 7'h0;
      tol_r      <= 10'h0;
      gap_r      <= 14'h0;
      phase_r    <= `PMW_RST_PHASE;
      int_en_r   <= '0;
    end else if (i_wr) begin
      if (wr_ctrl) begin
        mode_r <= i_wdata[`PMW_CTRL_MODE_MSB:`PMW_CTRL_MODE_LSB];
        upd_r  <= (i_wdata[`PMW_CTRL_UPD_MSB:`PMW_CTRL_UPD_LSB]
                   > `PMW_UPD_MAX) ? `PMW_UPD_MAX
                 : i_wdata[`PMW_CTRL_UPD_MSB:`PMW_CTRL_UPD_LSB];
      end
      unique case (i_addr)
        `PMW_OFF_WIN: win_r <= (i_wdata > 32'(`PMW_WIN_MAX))
                              ? `PMW_WIN_MAX : i_wdata[13:0];
        `PMW_OFF_MISS_LIM: miss_lim_r <= (i_wdata > 32'(`PMW_MISS_MAX))
                              ? `PMW_MISS_MAX : i_wdata[6:0];
        `PMW_OFF_TOL: tol_r <= (i_wdata > 32'(`PMW_TOL_MAX))
                              ? `PMW_TOL_MAX : i_wdata[9:0];
        `PMW_OFF_GAP: gap_r <= (i_wdata > 32'(`PMW_GAP_MAX))
                              ? `PMW_GAP_MAX : i_wdata[13:0];
        `PMW_OFF_PHASE: phase_r <= i_wdata[15:0];
        `PMW_OFF_INT_EN: int_en_r <= i_wdata[`PMW_INT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  always_comb begin
    int_evt                    = '0;
    int_evt[`PMW_INT_MARK_OK]  = mark_ok;
    int_evt[`PMW_INT_MARK_REJ] = mark_rej;
    int_evt[`PMW_INT_ABSENT]   = o_mark_absent & ~absent_d_r;
    int_evt[`PMW_INT_LEN_UPD]  = len_hit;
    int_evt[`PMW_INT_GAP_DONE] = gap_done;
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_stat_r <= '0;
    end else if (i_wr && i_addr == `PMW_OFF_INT_CLR) begin
      int_stat_r <= (int_stat_r & ~i_wdata[`PMW_INT_W-1:0]) | int_evt;
    end else begin
      int_stat_r <= int_stat_r | int_evt;
    end
  end

  // Level output while any enabled status bit is set
  assign o_irq = |(int_stat_r & int_en_r);

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  // Data valid the cycle after the read strobe only; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0;
    end else if (!i_rd) begin
      o_rdata <= 32'h0;
    end else begin
      unique case (i_addr)
        `PMW_OFF_CTRL:     o_rdata <= {25'h0, upd_r, 2'h0, mode_r};
        `PMW_OFF_WIN:      o_rdata <= {18'h0, win_r};
        `PMW_OFF_MISS_LIM: o_rdata <= {25'h0, miss_lim_r};
        `PMW_OFF_TOL:      o_rdata <= {22'h0, tol_r};
        `PMW_OFF_GAP:      o_rdata <= {18'h0, gap_r};
        `PMW_OFF_PHASE:    o_rdata <= {16'h0, phase_r};
        `PMW_OFF_PRESET:   o_rdata <= {8'h0, preset_r};
        `PMW_OFF_TAUGHT:   o_rdata <= taught_r;
        `PMW_OFF_STAT:     o_rdata <= {15'h0, taught_vld_r, 3'h0,
                                       run_r, 1'b0, miss_cnt_r};
        `PMW_OFF_INT_STAT: o_rdata <= {27'h0, int_stat_r};
        `PMW_OFF_INT_EN:   o_rdata <= {27'h0, int_en_r};
        default:           o_rdata <= 32'h0;
      endcase
    end
  end

endmodule : pmw_top
`default_nettype wire

// ### bench/pmw_top_chk.sv
// Port checker for the print-mark block
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_top_chk (
  // Clock, reset and bus writes
  input wire logic              i_clk_sys,
  input wire logic              i_rst_b,
  input wire logic [7:0]        i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  // Pins and controller inputs
  input wire logic              i_mark,
  input wire logic [31:0]       i_pos,
  input wire logic              i_cut_stb,
  // Outputs watched
  input wire logic              o_mark_stb,
  input wire logic [31:0]       o_mark_pos,
  input wire logic              o_mark_absent,
  input wire pmw_pkg::pmw_len_t o_len_preset,
  input wire logic [13:0]       o_gap_offs,
  input wire logic              o_gap_busy
);
  logic mark_mode_r, lim_zero_r;

  // Mirror of mode and missing limit taken from bus writes
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mark_mode_r <= 1'b0;
      lim_zero_r  <= 1'b1;
    end else if (i_wr) begin
      if (i_addr == `PMW_OFF_CTRL) mark_mode_r <= (i_wdata[1:0] == 2'h2);
      if (i_addr == `PMW_OFF_MISS_LIM) lim_zero_r <= (i_wdata == 32'h0);
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  // Gap divide or ramp running with no restart pending
  sequence s_ramp;
    o_gap_busy && !i_cut_stb;
  endsequence
  // Supervision off for three cycles
  sequence s_watch_off;
    (!mark_mode_r || lim_zero_r) [*3];
  endsequence

  property p_edge;
    o_mark_stb |-> $past(i_mark, 3) && !$past(i_mark, 4);
  endproperty
  a_edge: assert property (p_edge) else $error("no rise");
  property p_pulse;
    o_mark_stb |=> !o_mark_stb;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_mode;
    o_mark_stb |-> $past(mark_mode_r);
  endproperty
  a_mode: assert property (p_mode) else $error("wrong mode");
  property p_pos;
    o_mark_stb |-> o_mark_pos == $past(i_pos);
  endproperty
  a_pos: assert property (p_pos) else $error("bad position");
  property p_absent;
    s_watch_off |-> !o_mark_absent;
  endproperty
  a_absent: assert property (p_absent) else $error("absent set");
  property p_gap_go;
    $rose(o_gap_busy) |-> $past(i_cut_stb);
  endproperty
  a_gap_go: assert property (p_gap_go) else $error("no cut");
  property p_ramp;
    s_ramp |=> o_gap_offs >= $past(o_gap_offs);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp falls");
  property p_preset;
    $changed(o_len_preset) |-> o_mark_stb || $past(o_mark_stb) || $past(i_wr);
  endproperty
  a_preset: assert property (p_preset) else $error("preset moved");
endmodule : pmw_top_chk
`default_nettype wire

// ### bench/pmw_cell.sv
// Photocell and teach pin model
`timescale 1ns/1ps
`default_nettype none
module pmw_cell (
  // Clock and requests from the bench
  input wire logic i_clk_sys,
  input wire logic i_fire,
  input wire logic i_teach_req,
  // Pins
  output logic     o_mark,
  output logic     o_teach
);
  logic [2:0] hold_r = 3'h0;

  // Mark seen for four cycles per request
  always @(posedge i_clk_sys) begin
    if (i_fire) hold_r <= 3'h4;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end
  assign o_mark = (hold_r != 3'h0);

  // Teach dropped on the mark's last cycle
  initial o_teach = 1'b0;
  always @(posedge i_clk_sys) begin
    if (i_teach_req) o_teach <= 1'b1;
    else if (hold_r == 3'h1) o_teach <= 1'b0;
  end
endmodule : pmw_cell
`default_nettype wire

// ### bench/pmw_top_tb.sv
// Self-checking testbench of the print-mark block
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"
module pmw_top_tb;
  import pmw_pkg::*;
  logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_cut_stb, fire, teach_req;
  logic        i_mark, i_teach, o_mark_stb, o_mark_absent, o_gap_busy, o_irq;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, i_pos, o_rdata, o_mark_pos, p, lp;
  pmw_len_t    o_len_preset;
  logic [13:0] o_gap_offs;
  int          bad_count, total_checks, stb_cnt;

  pmw_top u_dut (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_mark, .i_teach, .i_pos, .i_cut_stb, .o_mark_stb,
    .o_mark_pos, .o_mark_absent, .o_len_preset, .o_gap_offs, .o_gap_busy,
    .o_irq);
  pmw_cell u_cell (.i_clk_sys, .i_fire(fire), .i_teach_req(teach_req),
    .o_mark(i_mark), .o_teach(i_teach));

  // Clock and strobe counter
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (o_mark_stb === 1'b1) stb_cnt++;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string w);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(w, e, o_rdata);
  endtask : rd
  task automatic cut(input logic [31:0] at);
    @(posedge i_clk_sys);
    i_pos <= at;
    i_cut_stb <= 1'b1;
    @(posedge i_clk_sys);
    i_cut_stb <= 1'b0;
    tick(3);
  endtask : cut
  task automatic mark(input logic [31:0] at, input logic tch, input int n);
    int n0;
    n0 = stb_cnt;
    @(posedge i_clk_sys);
    i_pos <= at;
    teach_req <= tch;
    tick(3);
    fire <= 1'b1;
    teach_req <= 1'b0;
    tick(1);
    fire <= 1'b0;
    tick(9);
    chk("mark strobes", 32'(n), 32'(stb_cnt - n0));
    if (n == 1) chk("mark position", at, o_mark_pos);
  endtask : mark
  task automatic step(input int d, input logic [31:0] ex);
    lp = lp + p + 32'(d);
    mark(lp, 1'b0, 1);
    chk("length preset", ex, 32'(o_len_preset));
  endtask : step

  // Reset values, unmapped place, clamping
  task automatic t_regs;
    logic [7:0]  a [4] = '{`PMW_OFF_WIN, `PMW_OFF_MISS_LIM, `PMW_OFF_TOL,
                           `PMW_OFF_CTRL};
    logic [31:0] w [4] = '{32'h4e20, 32'hc8, 32'h1388, 32'h71};
    logic [31:0] e [4] = '{32'h270f, 32'h63, 32'h3e7, 32'h51};
    rd(`PMW_OFF_CTRL, 32'h1, "control");
    rd(`PMW_OFF_PRESET, 32'h3e8, "preset");
    rd(`PMW_OFF_INT_CLR, 32'h0, "clear register");
    rd(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(a[i], w[i]);
      rd(a[i], e[i], "clamp");
    end
    mark(32'h100, 1'b1, 0);
  endtask : t_regs
  // Teach, window and missing marks
  task automatic t_window;
    wr(`PMW_OFF_CTRL, 32'h2);
    wr(`PMW_OFF_WIN, 32'd100);
    cut(32'd0);
    mark(32'd500, 1'b1, 1);
    rd(`PMW_OFF_TAUGHT, 32'd500, "taught");
    cut(32'd1000);
    mark(32'd1800, 1'b0, 0);
    mark(32'd1550, 1'b0, 1);
    mark(32'd1449, 1'b0, 0);
    wr(`PMW_OFF_WIN, 32'h0);
    mark(32'd1800, 1'b0, 1);
    wr(`PMW_OFF_MISS_LIM, 32'h2);
    cut(32'd2000);
    chk("mark absent", 32'h0, 32'(o_mark_absent));
    cut(32'd3000);
    chk("mark absent", 32'h0, 32'(o_mark_absent));
    cut(32'd4000);
    chk("mark absent", 32'h1, 32'(o_mark_absent));
    wr(`PMW_OFF_MISS_LIM, 32'h0);
    tick(3);
    chk("mark absent", 32'h0, 32'(o_mark_absent));
    wr(`PMW_OFF_MISS_LIM, 32'h2);
    tick(3);
    chk("mark absent", 32'h1, 32'(o_mark_absent));
    wr(`PMW_OFF_CTRL, 32'h1);
    tick(3);
    chk("mark absent", 32'h0, 32'(o_mark_absent));
  endtask : t_window
  // Tolerance, direction and run lengths of length update
  task automatic t_length;
    wr(`PMW_OFF_CTRL, 32'h2);
    wr(`PMW_OFF_TOL, 32'd50);
    p = 32'd1000;
    lp = 32'd50000;
    mark(lp, 1'b0, 1);
    step(60, p);
    wr(`PMW_OFF_CTRL, 32'h12);
    step(50, p);
    step(-51, p - 32'd51);
    p = p - 32'd51;
    wr(`PMW_OFF_CTRL, 32'h22);
    step(60, p);
    step(-60, p);
    step(-60, p - 32'd60);
    p = p - 32'd60;
    for (int s = 1; s <= 5; s++) begin
      wr(`PMW_OFF_CTRL, 32'(2 + (s << 4)));
      for (int i = 1; i <= (1 << (s - 1)); i++)
        step(60, (i == (1 << (s - 1))) ? p + 32'd60 : p);
      p = p + 32'd60;
    end
  endtask : t_length
  // Gap profile and interrupt
  task automatic t_gap;
    wr(`PMW_OFF_CTRL, 32'h1);
    wr(`PMW_OFF_INT_EN, 32'h0);
    wr(`PMW_OFF_INT_CLR, 32'h1f);
    wr(`PMW_OFF_PHASE, 32'd20);
    wr(`PMW_OFF_GAP, 32'd100);
    cut(32'd0);
    tick(20);
    chk("gap busy", 32'h1, 32'(o_gap_busy));
    chk("gap mid", 32'h1, 32'(o_gap_offs inside {[1:99]}));
    tick(20);
    chk("gap travel", 32'd100, 32'(o_gap_offs));
    chk("gap busy", 32'h0, 32'(o_gap_busy));
    chk("irq", 32'h0, 32'(o_irq));
    wr(`PMW_OFF_INT_EN, 32'h10);
    tick(1);
    chk("irq", 32'h1, 32'(o_irq));
    rd(`PMW_OFF_INT_STAT, 32'h10, "int status");
    wr(`PMW_OFF_INT_CLR, 32'h10);
    tick(1);
    chk("irq", 32'h0, 32'(o_irq));
    wr(`PMW_OFF_GAP, 32'h0);
    cut(32'd0);
    chk("gap busy", 32'h0, 32'(o_gap_busy));
  endtask : t_gap

  // Main sequence
  initial begin
    {i_rst_b, i_wr, i_rd, i_cut_stb, fire, teach_req} = 6'h0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_pos = 32'h0;
    tick(16);
    i_rst_b <= 1'b1;
    t_regs;
    t_window;
    t_length;
    t_gap;
    print_verdict;
  end
  // Watchdog
  initial begin
    tick(20000);
    bad_count++;
    print_verdict;
  end
endmodule : pmw_top_tb
bind pmw_top pmw_top_chk u_chk (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata,
  .i_wr, .i_mark, .i_pos, .i_cut_stb, .o_mark_stb, .o_mark_pos,
  .o_mark_absent, .o_len_preset, .o_gap_offs, .o_gap_busy);
`default_nettype wire
